/* csbc_pkg.sv */
// Purpose: shared constants and types for the core state and bundle check
// Assumes: 32-bit syllables, up to four per bundle
// Notes: syllable field layout is this block's own encoding
package csbc_pkg;
  localparam int XLEN = 32;
  localparam int NGPR = 64;
  localparam int GIDX = 6;
  localparam int NCOND = 8;
  localparam int CIDX = 3;
  localparam int CW = 4;
  localparam int NSYL = 4;
  localparam int SIDX = 2;
  localparam int LENW = 3;
  // --------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------
  localparam logic [GIDX-1:0] ZERO_REGISTER = 6'h00;
  localparam logic [GIDX-1:0] LINK_REGISTER = 6'h3F;
  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  localparam int SW_USER = 0;
  localparam int SW_INT_EN = 1;
  localparam int SW_XLATE = 2;
  localparam int SW_TCM_ONLY = 5;
  localparam int SW_DATA_WATCH = 8;
  localparam int SW_FETCH_WATCH = 9;
  localparam int SW_DEBUG = 12;
  localparam logic [XLEN-1:0] SW_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] SW_WRITABLE = 32'h0000_1327;
  localparam logic [XLEN-1:0] SW_TCM_BIT = 32'h0000_0020;
  localparam logic [XLEN-1:0] PC_ALIGN = 32'hFFFF_FFFC;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
  // --------------------------------------------------------------
  // syllable fields
  // --------------------------------------------------------------
  localparam int SY_STOP = 31;
  localparam int SY_RSV = 30;
  localparam int SY_CLS_HI = 29;
  localparam int SY_CLS_LO = 26;
  localparam int SY_DST_HI = 25;
  localparam int SY_DST_LO = 20;
  localparam int SY_DCOND = 19;
  localparam int SY_HASD = 18;
  localparam int SY_EXT = 17;
  localparam int SY_TGT_HI = 16;
  localparam int SY_TGT_LO = 15;
  localparam logic [XLEN-1:0] IMMX_UNUSED = 32'h03FE_0000;
  localparam logic [XLEN-1:0] OP_UNUSED = 32'h0001_8000;
  typedef enum logic [3:0] {
    CLS_ALU = 4'h0, CLS_MUL = 4'h1, CLS_FPN = 4'h2, CLS_LSU = 4'h3,
    CLS_BRANCH = 4'h4, CLS_CALL = 4'h5, CLS_RFI = 4'h6,
    CLS_SWMASK = 4'h7, CLS_IMMX = 4'h8
  } csbc_cls_type;
  typedef enum logic [2:0] {
    WK_GPR = 3'h0, WK_COND_SCALAR = 3'h1, WK_COND_SIMD16 = 3'h2,
    WK_COND_SIMD8 = 3'h3, WK_COND_FROM_GPR = 3'h4, WK_GPR_FROM_COND = 3'h5
  } csbc_wk_type;
endpackage

/* csbc_rf_if.sv */
// Purpose: carrier between core state and general register memory
// Assumes: one read port, two write ports
// Notes: port b wins on equal write address
`timescale 1ns/1ps
interface csbc_rf_if #(parameter int AW = 6, parameter int DW = 32);
  logic we_a;
  logic [AW-1:0] wa_a;
  logic [DW-1:0] wd_a;
  logic we_b;
  logic [AW-1:0] wa_b;
  logic [DW-1:0] wd_b;
  logic [AW-1:0] ra;
  logic [DW-1:0] rd;
  modport mem (input we_a, wa_a, wd_a, we_b, wa_b, wd_b, ra, output rd);
  modport core (output we_a, wa_a, wd_a, we_b, wa_b, wd_b, ra, input rd);
endinterface

/* csbc_gpr_mem.sv */
// Purpose: general register array with registered read
// Assumes: index zero is the zero register
// Notes: array itself has no reset
`timescale 1ns/1ps
module csbc_gpr_mem
  import csbc_pkg::*;
#(
  parameter int DEPTH = NGPR,
  parameter int AW = GIDX,
  parameter int DW = XLEN
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // register port
  csbc_rf_if.mem rf
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rd_q;

  // --------------------------------------------------------------
  // writes
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (rf.we_a && rf.wa_a != ZERO_REGISTER) begin
      mem_q[rf.wa_a] <= rf.wd_a;
    end
    if (rf.we_b && rf.wa_b != ZERO_REGISTER) begin
      mem_q[rf.wa_b] <= rf.wd_b;
    end
  end

  // --------------------------------------------------------------
  // read
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_q <= '0;
    end else if (rf.ra == ZERO_REGISTER) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_q[rf.ra];
    end
  end

  assign rf.rd = rd_q;
endmodule // csbc_gpr_mem

/* csbc_syl_chk.sv */
// Purpose: per-syllable legality and resource classification
// Assumes: slot index and word parity supplied by caller
// Notes: purely combinational
`timescale 1ns/1ps
module csbc_syl_chk
  import csbc_pkg::*;
(
  // syllable
  input wire logic [XLEN-1:0] i_syl,
  input wire logic [SIDX-1:0] i_slot,
  input wire logic i_odd,
  input wire logic i_user,
  // classification
  output logic o_bad,
  output logic o_lsu,
  output logic o_immx,
  output logic o_ext,
  output logic [SIDX-1:0] o_tgt,
  output logic o_dst_en,
  output logic [GIDX:0] o_dst_key
);
  csbc_cls_type cls;
  logic known;

  always_comb begin
    cls = csbc_cls_type'(i_syl[SY_CLS_HI:SY_CLS_LO]);
    known = (i_syl[SY_CLS_HI:SY_CLS_LO] <= CLS_IMMX);
    o_immx = known && cls == CLS_IMMX;
    o_lsu = known && (cls == CLS_LSU || cls == CLS_RFI || cls == CLS_SWMASK);
    o_ext = i_syl[SY_EXT] && !o_immx;
    o_tgt = i_syl[SY_TGT_HI:SY_TGT_LO];
    o_dst_en = i_syl[SY_HASD] && !o_immx;
    o_dst_key = {i_syl[SY_DCOND], i_syl[SY_DST_HI:SY_DST_LO]};
    if (known && cls == CLS_CALL) begin
      o_dst_en = 1'b1;
      o_dst_key = {1'b0, LINK_REGISTER};
    end
    if (!i_syl[SY_DCOND] && o_dst_key[GIDX-1:0] == ZERO_REGISTER) begin
      o_dst_en = 1'b0;
    end
    o_bad = !known || i_syl[SY_RSV];
    if (o_immx) begin
      o_bad = o_bad || (i_syl & IMMX_UNUSED) != '0 || i_odd;
    end else begin
      o_bad = o_bad || (i_syl & OP_UNUSED) != '0;
    end
    if (known && (cls == CLS_BRANCH || cls == CLS_CALL || cls == CLS_RFI)) begin
      o_bad = o_bad || i_slot != '0;
    end
    if (known && cls == CLS_MUL) begin
      o_bad = o_bad || !i_odd;
    end
    if (known && cls == CLS_FPN) begin
      o_bad = o_bad || i_odd;
    end
    if (known && (cls == CLS_RFI || cls == CLS_SWMASK)) begin
      o_bad = o_bad || i_user;
    end
  end
endmodule // csbc_syl_chk

/* csbc_core_state.sv */
// Purpose: architectural state of the core and bundle legality check
// Assumes: bundle syllables, operands and targets come from decode
// Notes: an illegal bundle changes no state; pc stays on it
`timescale 1ns/1ps
module csbc_core_state
  import csbc_pkg::*;
#(
  parameter bit HAS_TCM = 1'b1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // bundle
  input wire logic i_bundle_valid,
  input wire logic [NSYL-1:0][XLEN-1:0] i_bundle,
  input wire logic i_branch_taken,
  input wire logic [XLEN-1:0] i_branch_target,
  input wire logic [XLEN-1:0] i_mask_bits,
  input wire logic [XLEN-1:0] i_mask_value,
  input wire logic [XLEN-1:0] i_trap_return_pc,
  input wire logic [XLEN-1:0] i_trap_saved_status,
  // writeback
  input wire logic i_wr_valid,
  input wire csbc_wk_type i_wr_kind,
  input wire logic [GIDX-1:0] i_wr_idx,
  input wire logic [CIDX-1:0] i_wr_src,
  input wire logic [XLEN-1:0] i_wr_data,
  // reads
  input wire logic [GIDX-1:0] i_gpr_rd_idx,
  input wire logic [CIDX-1:0] i_cond_rd_idx,
  // events
  input wire logic i_debug_trap,
  input wire logic i_context_switch,
  input wire logic i_lock_acquire,
  input wire logic i_lsu_req,
  input wire logic i_lsu_cached,
  input wire logic i_lsu_in_tcm,
  // state
  output logic [XLEN-1:0] o_pc,
  output logic [XLEN-1:0] o_status_word,
  output logic [XLEN-1:0] o_mask_old,
  output logic [XLEN-1:0] o_gpr_rd_data,
  output logic [CW-1:0] o_cond_raw,
  output logic [CW-1:0] o_cond_bool,
  // status
  output logic o_bundle_done,
  output logic o_illegal_instruction_exception,
  output logic o_cache_disabled_exc,
  output logic o_lock,
  output logic o_shadow_lock,
  output logic o_data_watch_on,
  output logic o_fetch_watch_on
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [CW-1:0] to_bool(input logic [CW-1:0] v);
    to_bool = (v != '0) ? 4'h1 : 4'h0;
  endfunction

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [XLEN-1:0] pc_q;
  logic [XLEN-1:0] sw_q;
  logic [XLEN-1:0] sw_d;
  logic [XLEN-1:0] sw_wmask;
  logic [XLEN-1:0] mask_old_q;
  logic [CW-1:0] cond_q [NCOND];
  logic [CW-1:0] cond_raw_q;
  logic [CW-1:0] cond_bool_q;
  logic done_q;
  logic ill_q;
  logic cdis_q;
  logic lock_q;
  logic shadow_q;
  logic user_eff;
  logic [NSYL-1:0] bad;
  logic [NSYL-1:0] lsu;
  logic [NSYL-1:0] immx;
  logic [NSYL-1:0] ext;
  logic [NSYL-1:0] dst_en;
  logic [SIDX-1:0] tgt [NSYL];
  logic [GIDX:0] dkey [NSYL];
  logic [LENW-1:0] len;
  logic found;
  logic illegal;
  logic commit;
  logic [NSYL-1:0] in_b;
  logic [XLEN-1:0] next_pc;
  csbc_cls_type cls0;

  csbc_rf_if #(.AW(GIDX), .DW(XLEN)) rf ();

  // --------------------------------------------------------------
  // per-syllable checks
  // --------------------------------------------------------------
  assign user_eff = sw_q[SW_USER] && !sw_q[SW_DEBUG];

  for (genvar k = 0; k < NSYL; k++) begin : g_syl
    csbc_syl_chk u_chk (
      .i_syl(i_bundle[k]),
      .i_slot(SIDX'(k)),
      .i_odd(pc_q[2] ^ 1'(k % 2)),
      .i_user(user_eff),
      .o_bad(bad[k]),
      .o_lsu(lsu[k]),
      .o_immx(immx[k]),
      .o_ext(ext[k]),
      .o_tgt(tgt[k]),
      .o_dst_en(dst_en[k]),
      .o_dst_key(dkey[k])
    );
  end

  // --------------------------------------------------------------
  // bundle-level checks
  // --------------------------------------------------------------
  always_comb begin
    int nlsu;
    nlsu = 0;
    len = '0;
    found = 1'b0;
    in_b = '0;
    for (int k = 0; k < NSYL; k++) begin
      if (!found) begin
        in_b[k] = 1'b1;
        if (i_bundle[k][SY_STOP]) begin
          found = 1'b1;
          len = LENW'(k + 1);
        end
      end
    end
    illegal = !found;
    for (int k = 0; k < NSYL; k++) begin
      if (in_b[k]) begin
        illegal = illegal || bad[k];
        if (lsu[k]) begin
          nlsu = nlsu + 1;
        end
        if (immx[k]) begin
          illegal = illegal || !in_b[tgt[k]] || !ext[tgt[k]] || tgt[k] == SIDX'(k);
        end
        for (int j = k + 1; j < NSYL; j++) begin
          if (in_b[j]) begin
            if (dst_en[k] && dst_en[j] && dkey[k] == dkey[j]) begin
              illegal = 1'b1;
            end
            if (immx[k] && immx[j] && tgt[k] == tgt[j]) begin
              illegal = 1'b1;
            end
          end
        end
      end
    end
    illegal = illegal || nlsu > 1;
    commit = i_bundle_valid && !illegal;
  end

  assign cls0 = csbc_cls_type'(i_bundle[0][SY_CLS_HI:SY_CLS_LO]);
  assign next_pc = o_pc + {{(XLEN-LENW-2){1'b0}}, len, 2'b00};

  // --------------------------------------------------------------
  // program counter
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_q <= PC_RESET;
    end else if (commit) begin
      if (cls0 == CLS_RFI) begin
        pc_q <= i_trap_return_pc & PC_ALIGN;
      end else if ((cls0 == CLS_BRANCH || cls0 == CLS_CALL) && i_branch_taken) begin
        pc_q <= i_branch_target & PC_ALIGN;
      end else begin
        pc_q <= next_pc & PC_ALIGN;
      end
    end
  end

  // --------------------------------------------------------------
  // status word
  // --------------------------------------------------------------
  assign sw_wmask = HAS_TCM ? SW_WRITABLE : (SW_WRITABLE & ~SW_TCM_BIT);

  always_comb begin
    sw_d = sw_q;
    if (commit && cls0 == CLS_RFI) begin
      sw_d = i_trap_saved_status & sw_wmask;
      if (!sw_q[SW_DEBUG]) begin
        sw_d[SW_DEBUG] = 1'b0;
      end
    end
    for (int k = 0; k < NSYL; k++) begin
      if (commit && in_b[k] && i_bundle[k][SY_CLS_HI:SY_CLS_LO] == CLS_SWMASK) begin
        sw_d = (sw_q & ~(i_mask_bits & sw_wmask)) | (i_mask_value & i_mask_bits & sw_wmask);
        if (!sw_q[SW_DEBUG]) begin
          sw_d[SW_DEBUG] = 1'b0;
        end
      end
    end
    if (i_debug_trap && !sw_q[SW_DEBUG]) begin
      sw_d[SW_DEBUG] = 1'b1;
      sw_d[SW_USER] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_q <= SW_RESET;
    end else begin
      sw_q <= sw_d & sw_wmask;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mask_old_q <= '0;
    end else if (commit && (|(lsu & in_b)) && cls0 != CLS_RFI) begin
      mask_old_q <= sw_q;
    end
  end

  // --------------------------------------------------------------
  // general registers
  // --------------------------------------------------------------
  csbc_gpr_mem u_gpr (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .rf(rf)
  );

  always_comb begin
    rf.we_a = i_wr_valid && (i_wr_kind == WK_GPR || i_wr_kind == WK_GPR_FROM_COND);
    rf.wa_a = i_wr_idx;
    rf.wd_a = i_wr_data;
    if (i_wr_kind == WK_GPR_FROM_COND) begin
      rf.wd_a = {{(XLEN-CW){1'b0}}, cond_q[i_wr_src]};
    end
    rf.we_b = commit && cls0 == CLS_CALL;
    rf.wa_b = LINK_REGISTER;
    rf.wd_b = next_pc;
    rf.ra = i_gpr_rd_idx;
  end

  // --------------------------------------------------------------
  // condition registers
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < NCOND; k++) begin
        cond_q[k] <= '0;
      end
    end else if (i_wr_valid) begin
      unique case (i_wr_kind)
        WK_COND_SCALAR: begin
          cond_q[i_wr_idx[CIDX-1:0]] <= to_bool(i_wr_data[CW-1:0]);
        end
        WK_COND_SIMD16: begin
          cond_q[i_wr_idx[CIDX-1:0]] <= {1'b0, i_wr_data[1], 1'b0, i_wr_data[0]};
        end
        WK_COND_SIMD8: begin
          cond_q[i_wr_idx[CIDX-1:0]] <= i_wr_data[CW-1:0];
        end
        WK_COND_FROM_GPR: begin
          cond_q[i_wr_idx[CIDX-1:0]] <= i_wr_data[CW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cond_raw_q <= '0;
      cond_bool_q <= '0;
    end else begin
      cond_raw_q <= cond_q[i_cond_rd_idx];
      cond_bool_q <= to_bool(cond_q[i_cond_rd_idx]);
    end
  end

  // --------------------------------------------------------------
  // events and exceptions
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      cdis_q <= 1'b0;
    end else begin
      done_q <= commit;
      ill_q <= i_bundle_valid && illegal;
      cdis_q <= i_lsu_req && i_lsu_cached && !i_lsu_in_tcm && sw_q[SW_TCM_ONLY];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lock_q <= 1'b0;
      shadow_q <= 1'b0;
    end else begin
      if (i_context_switch) begin
        shadow_q <= lock_q;
      end
      if (i_lock_acquire) begin
        lock_q <= 1'b1;
      end else if (i_context_switch) begin
        lock_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign o_pc = pc_q;
  assign o_status_word = sw_q;
  assign o_mask_old = mask_old_q;
  assign o_gpr_rd_data = rf.rd;
  assign o_cond_raw = cond_raw_q;
  assign o_cond_bool = cond_bool_q;
  assign o_bundle_done = done_q;
  assign o_illegal_instruction_exception = ill_q;
  assign o_cache_disabled_exc = cdis_q;
  assign o_lock = lock_q;
  assign o_shadow_lock = shadow_q;
  assign o_data_watch_on = sw_q[SW_DATA_WATCH];
  assign o_fetch_watch_on = sw_q[SW_FETCH_WATCH];
endmodule // csbc_core_state

/* csbc_fetch_model.sv */
// Purpose: fetch-side model that hands bundles to the core state
// Assumes: one bundle per go pulse, valid held for one cycle
// Notes: idle syllable lines invert each cycle, so the stale bundle comes back every second cycle
`timescale 1ns/1ps
module csbc_fetch_model
  import csbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // request
  input wire logic i_go,
  input wire logic [NSYL-1:0][XLEN-1:0] i_next,
  // bundle
  output logic o_valid,
  output logic [NSYL-1:0][XLEN-1:0] o_bundle
);
  // --------------------------------------------------------------
  // bundle presentation
  // --------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_bundle <= '0;
    end else begin
      o_valid <= i_go;
      o_bundle <= i_go ? i_next : ~o_bundle;
    end
  end
endmodule // csbc_fetch_model

/* csbc_core_properties.sv */
// Purpose: port-level checks of the core state and bundle check
// Assumes: one clock, asynchronous active-low reset
// Notes: bound into csbc_core_state
`timescale 1ns/1ps
module csbc_core_properties
  import csbc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // inputs
  input wire logic i_bundle_valid,
  input wire logic [NSYL-1:0][XLEN-1:0] i_bundle,
  input wire logic i_debug_trap,
  input wire logic i_context_switch,
  input wire logic i_lock_acquire,
  input wire logic i_lsu_req,
  input wire logic i_lsu_cached,
  input wire logic i_lsu_in_tcm,
  // outputs
  input wire logic [XLEN-1:0] o_pc,
  input wire logic [XLEN-1:0] o_status_word,
  input wire logic o_bundle_done,
  input wire logic o_illegal_instruction_exception,
  input wire logic o_cache_disabled_exc,
  input wire logic o_lock,
  input wire logic o_shadow_lock
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_pc_align: assert property (o_pc[1:0] == 2'h0)
    else $error("pc not word aligned");
  a_illegal_pc_hold: assert property (o_illegal_instruction_exception |->
    o_pc == $past(o_pc)) else $error("pc moved on illegal bundle");
  a_bundle_answer: assert property (i_bundle_valid |=>
    o_bundle_done != o_illegal_instruction_exception) else $error("bundle answer wrong");
  a_no_stop_bit: assert property (i_bundle_valid && !i_bundle[0][31] &&
    !i_bundle[1][31] && !i_bundle[2][31] && !i_bundle[3][31]
    |=> o_illegal_instruction_exception) else $error("stopless bundle accepted");
  a_user_privileged: assert property (i_bundle_valid && o_status_word[SW_USER] &&
    !o_status_word[SW_DEBUG] && i_bundle[0][29:26] == CLS_SWMASK
    |=> o_illegal_instruction_exception) else $error("privileged op in user mode");
  a_mul_even_word: assert property (i_bundle_valid && !o_pc[2] &&
    i_bundle[0][29:26] == CLS_MUL |=> o_illegal_instruction_exception)
    else $error("multiply at even word accepted");
  a_reserved_zero: assert property ((o_status_word & ~SW_WRITABLE) == 32'h0)
    else $error("reserved status bit set");
  a_cache_disabled: assert property (i_lsu_req && i_lsu_cached && !i_lsu_in_tcm &&
    o_status_word[SW_TCM_ONLY] |=> o_cache_disabled_exc) else $error("no cache fault");
  a_debug_entry: assert property (i_debug_trap && !o_status_word[SW_DEBUG] |=>
    o_status_word[SW_DEBUG] && !o_status_word[SW_USER]) else $error("debug entry wrong");
  a_switch_lock: assert property (i_context_switch && !i_lock_acquire |=>
    !o_lock && o_shadow_lock == $past(o_lock)) else $error("lock not saved");
  c_legal: cover property (i_bundle_valid ##1 o_bundle_done);
  c_illegal: cover property (i_bundle_valid ##1 o_illegal_instruction_exception);
  c_switch: cover property (i_context_switch && o_lock);
endmodule // csbc_core_properties

bind csbc_core_state csbc_core_properties u_props (.i_clk, .i_nrst, .i_bundle_valid,
  .i_bundle, .i_debug_trap, .i_context_switch, .i_lock_acquire, .i_lsu_req, .i_lsu_cached,
  .i_lsu_in_tcm, .o_pc, .o_status_word, .o_bundle_done, .o_illegal_instruction_exception,
  .o_cache_disabled_exc, .o_lock, .o_shadow_lock);

/* testbench.sv */
// Purpose: self-checking bench for csbc_core_state
// Assumes: tightly coupled memory present, bundles come from csbc_fetch_model
// Notes: expected values come from the model state kept below
`timescale 1ns/1ps
module testbench;
  import csbc_pkg::*;
  // --------------------------------------------------------------
  // stimulus, model state and counters
  // --------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic go = 1'b0;
  logic i_branch_taken = 1'b0;
  logic i_wr_valid = 1'b0;
  logic [5:0] ev = '0;
  logic [5:0] i_wr_idx = '0, i_gpr_rd_idx = '0;
  logic [2:0] i_wr_src = '0, i_cond_rd_idx = '0;
  logic [31:0] i_branch_target = '0, i_mask_bits = '0, i_mask_value = '0;
  logic [31:0] i_trap_return_pc = '0, i_trap_saved_status = '0, i_wr_data = '0;
  logic [NSYL-1:0][XLEN-1:0] nxt = '0;
  logic [NSYL-1:0][XLEN-1:0] i_bundle;
  csbc_wk_type i_wr_kind = WK_GPR;
  logic i_bundle_valid, o_bundle_done, o_illegal_instruction_exception, o_cache_disabled_exc;
  logic o_lock, o_shadow_lock, o_data_watch_on, o_fetch_watch_on;
  logic [31:0] o_pc, o_status_word, o_mask_old, o_gpr_rd_data;
  logic [3:0] o_cond_raw, o_cond_bool;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'hC290;
  int unsigned m_pc = 0;
  int unsigned m_sw = 0;
  int unsigned mg [64];
  int mc [8];
  int i;
  int g;
  logic [31:0] d;
  always #4 i_clk = ~i_clk;
  csbc_fetch_model i_fetch (.i_clk, .i_nrst, .i_go(go), .i_next(nxt),
    .o_valid(i_bundle_valid), .o_bundle(i_bundle));
  csbc_core_state #(.HAS_TCM(1'b1)) i_dut (.i_clk, .i_nrst, .i_bundle_valid, .i_bundle,
    .i_branch_taken, .i_branch_target, .i_mask_bits, .i_mask_value, .i_trap_return_pc,
    .i_trap_saved_status, .i_wr_valid, .i_wr_kind, .i_wr_idx, .i_wr_src, .i_wr_data,
    .i_gpr_rd_idx, .i_cond_rd_idx, .i_debug_trap(ev[0]), .i_context_switch(ev[1]),
    .i_lock_acquire(ev[2]), .i_lsu_req(ev[3]), .i_lsu_cached(ev[4]), .i_lsu_in_tcm(ev[5]),
    .o_pc, .o_status_word, .o_mask_old, .o_gpr_rd_data, .o_cond_raw, .o_cond_bool,
    .o_bundle_done, .o_illegal_instruction_exception, .o_cache_disabled_exc, .o_lock,
    .o_shadow_lock, .o_data_watch_on, .o_fetch_watch_on);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] sy(input int s, input int c, input int r, input int h);
    return {s[0], 1'b0, c[3:0], r[5:0], 1'b0, h[0], 18'h0};
  endfunction
  function automatic int cf(input csbc_wk_type k, input logic [31:0] v);
    case (k)
      WK_COND_SCALAR: return int'(v[3:0] != 4'h0);
      WK_COND_SIMD16: return {v[1], 1'b0, v[0]};
      default: return v[3:0];
    endcase
  endfunction
  // ok: 0 refused, 1 sequential, 2 caller has set the model pc
  task automatic bun(input logic [31:0] s0, s1, s2, s3, input int ok);
    logic [NSYL-1:0][XLEN-1:0] b;
    int len;
    int n;
    b = {s3, s2, s1, s0};
    len = 0;
    for (n = 3; n >= 0; n--) if (b[n][31]) len = n + 1;
    @(posedge i_clk);
    go <= 1'b1;
    nxt <= b;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    for (n = 0; n < 4 && o_bundle_done !== 1'b1 && o_illegal_instruction_exception !== 1'b1;
         n++) begin
      @(posedge i_clk);
      #1;
    end
    if (n == 4) begin
      miscompares++;
      test_done();
    end
    if (ok == 1) m_pc = m_pc + 4 * len;
    chk(o_illegal_instruction_exception, ok == 0);
    chk(o_bundle_done, ok != 0);
    chk(o_pc, m_pc);
    chk(o_status_word, m_sw);
  endtask
  task automatic wr(input csbc_wk_type k, input int a, input int s, input logic [31:0] v);
    @(posedge i_clk);
    i_wr_valid <= 1'b1;
    i_wr_kind <= k;
    i_wr_idx <= a[5:0];
    i_wr_src <= s[2:0];
    i_wr_data <= v;
    @(posedge i_clk);
    i_wr_valid <= 1'b0;
  endtask
  task automatic rd(input int a, input int c);
    @(posedge i_clk);
    i_gpr_rd_idx <= a[5:0];
    i_cond_rd_idx <= c[2:0];
    @(posedge i_clk);
    #1;
  endtask
  task automatic pul(input logic [5:0] v);
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= '0;
    #1;
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    chk(o_pc, PC_RESET);
    chk(o_status_word, SW_RESET);
    bun(sy(0, CLS_ALU, 1, 1), sy(1, CLS_MUL, 2, 1), 0, 0, 1);
    bun(sy(1, CLS_MUL, 2, 1), 0, 0, 0, 0);
    bun(sy(0, CLS_ALU, 3, 1), sy(0, CLS_ALU, 4, 1), sy(0, 0, 6, 1), sy(0, 0, 7, 1), 0);
    bun(sy(1, CLS_ALU, 3, 1) | 32'h4000_0000, 0, 0, 0, 0);
    bun(sy(1, 9, 3, 1), 0, 0, 0, 0);
    bun(sy(0, CLS_ALU, 5, 1), sy(1, CLS_ALU, 5, 1), 0, 0, 0);
    bun(sy(0, CLS_ALU, 0, 1), sy(1, CLS_ALU, 0, 1), 0, 0, 1);
    bun(sy(0, CLS_LSU, 0, 0), sy(1, CLS_LSU, 0, 0), 0, 0, 0);
    bun(sy(0, CLS_ALU, 0, 0) | 32'h0002_0000, sy(1, CLS_IMMX, 0, 0), 0, 0, 0);
    bun(sy(0, CLS_IMMX, 0, 0) | 32'h8000, sy(1, 0, 0, 0) | 32'h0002_0000, 0, 0, 1);
    bun(sy(0, CLS_ALU, 0, 0), sy(1, CLS_BRANCH, 0, 0), 0, 0, 0);
    bun(sy(0, CLS_ALU, 0, 0), sy(1, CLS_FPN, 0, 0), 0, 0, 0);
    @(posedge i_clk);
    i_mask_bits <= 32'hFFFF_FFFF;
    i_mask_value <= SW_WRITABLE;
    m_sw = SW_WRITABLE & ~32'h0000_1000;
    bun(sy(1, CLS_SWMASK, 0, 0), 0, 0, 0, 1);
    chk(o_mask_old, SW_RESET);
    chk({o_fetch_watch_on, o_data_watch_on}, 2'h3);
    pul(6'h18);
    chk(o_cache_disabled_exc, 1'b1);
    pul(6'h38);
    chk(o_cache_disabled_exc, 1'b0);
    bun(sy(1, CLS_SWMASK, 0, 0), 0, 0, 0, 0);
    bun(sy(1, CLS_RFI, 0, 0), 0, 0, 0, 0);
    pul(6'h01);
    m_sw = (m_sw & ~32'h1) | 32'h0000_1000;
    chk(o_status_word, m_sw);
    @(posedge i_clk);
    i_trap_return_pc <= 32'h0000_0103;
    i_trap_saved_status <= 32'hFFFF_FFFF;
    m_pc = 32'h0000_0100;
    m_sw = SW_WRITABLE;
    bun(sy(1, CLS_RFI, 0, 0), 0, 0, 0, 2);
    @(posedge i_clk);
    i_mask_value <= 32'h0000_0000;
    m_sw = 0;
    bun(sy(1, CLS_SWMASK, 0, 0), 0, 0, 0, 1);
    chk(o_mask_old, SW_WRITABLE);
    @(posedge i_clk);
    i_branch_taken <= 1'b1;
    i_branch_target <= 32'h0000_0203;
    mg[63] = m_pc + 4;
    m_pc = 32'h0000_0200;
    bun(sy(1, CLS_CALL, 0, 0), 0, 0, 0, 2);
    rd(63, 0);
    chk(o_gpr_rd_data, mg[63]);
    for (i = 0; i < 4; i++) begin
      g = 1 + ({$random(seed)} % 62);
      d = $random(seed);
      wr(WK_GPR, g, 0, d);
      mg[g] = d;
      rd(g, 0);
      chk(o_gpr_rd_data, mg[g]);
    end
    wr(WK_GPR, 0, 0, 32'hFFFF_FFFF);
    rd(0, 0);
    chk(o_gpr_rd_data, 32'h0);
    for (i = 1; i < 5; i++) begin
      d = $random(seed);
      wr(csbc_wk_type'(i), i, 0, d);
      mc[i] = cf(csbc_wk_type'(i), d);
      rd(0, i);
      chk(o_cond_raw, mc[i]);
      chk(o_cond_bool, mc[i] != 0);
    end
    wr(WK_GPR_FROM_COND, 10, 2, 32'hFFFF_FFFF);
    rd(10, 0);
    chk(o_gpr_rd_data, mc[2]);
    pul(6'h04);
    chk(o_lock, 1'b1);
    pul(6'h02);
    chk({o_lock, o_shadow_lock}, 2'h1);
    m_pc = 32'h0000_0100;
    m_sw = SW_WRITABLE & ~32'h0000_1000;
    bun(sy(1, CLS_RFI, 0, 0), 0, 0, 0, 2);
    test_done();
  end
endmodule // testbench
